// ==== verilog/pllcg_regs.vh ====
// register map, field layout, reset values and timing constants of the
// clock generator; included by every design file of the block
`ifndef PLLCG_REGS_VH
`define PLLCG_REGS_VH

// register indices on the plain register port
`define PLLCG_ADDR_W          4
`define PLLCG_IDX_CSR         4'h0
`define PLLCG_IDX_MULT        4'h1
`define PLLCG_IDX_PRESCALE    4'h2
`define PLLCG_IDX_OSCDIV      4'h3
`define PLLCG_IDX_CORE_DIV    4'h4
`define PLLCG_IDX_PERIPH_DIV  4'h5
`define PLLCG_IDX_MEM_DIV     4'h6

// control/status fields
`define PLLCG_CSR_PATH_BIT    0
`define PLLCG_CSR_RESET_BIT   3
`define PLLCG_CSR_STABLE_BIT  6
`define PLLCG_DIV_EN_BIT      15
`define PLLCG_RATIO_W         5
`define PLLCG_RATIO_MSB       4

// reset values (ratio field n divides by n+1)
`define PLLCG_RST_PATH        1'b0
`define PLLCG_RST_LOOPRST     1'b1
`define PLLCG_RST_MULT        5'h04
`define PLLCG_RST_PRESCALE    5'h00
`define PLLCG_RST_OSCDIV      5'h00
`define PLLCG_RST_CORE_DIV    5'h00
`define PLLCG_RST_PERIPH_DIV  5'h01
`define PLLCG_RST_MEM_DIV     5'h01
`define PLLCG_RST_EN          1'b1

// multiply factors
`define PLLCG_MULT_BASIC_LOOP 5'h04
`define PLLCG_MULT_MIN        5'h04
`define PLLCG_MULT_MAX        5'h19

// timing: worst lock time is the typical 75 us plus 150 percent
`define PLLCG_LOCK_TYP_NS     75000
`define PLLCG_LOCK_MAX_NS     187500
`define PLLCG_RESET_MIN_NS    125
`define PLLCG_MCLK_PERIOD_NS  5

`endif

// ==== verilog/pllcg_div.v ====
// programmable integer clock divider working on clock-enable ticks
// assumes i_tick is a one-cycle pulse in the i_mclk domain
`timescale 1ns/1ps
`default_nettype none
`include "pllcg_regs.vh"

module pllcg_div #(
	parameter W = `PLLCG_RATIO_W
) (
	input  wire         i_mclk,   // master clock
	input  wire         i_rst,    // async reset, active high
	input  wire         i_ce,     // clock enable, freezes state
	input  wire         i_tick,   // input clock edge pulse
	input  wire         i_en,     // divider enable
	input  wire [W-1:0] i_ratio,  // divide by i_ratio+1
	output wire         o_tick    // divided clock edge pulse
);

	reg [W-1:0] cnt_q;
	reg [W-1:0] ratio_q;
	reg         tick_q;

	// count input edges; take a new ratio when a period completes or while disabled
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q   <= {W{1'b0}};
			ratio_q <= {W{1'b0}};
			tick_q  <= 1'b0;
		end else if (i_ce) begin
			tick_q <= 1'b0;
			if (!i_en) begin
				cnt_q   <= {W{1'b0}};
				ratio_q <= i_ratio;
			end else if (i_tick) begin
				if (cnt_q == ratio_q) begin
					cnt_q   <= {W{1'b0}};
					ratio_q <= i_ratio;
					tick_q  <= 1'b1;
				end else begin
					cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

	assign o_tick = tick_q;

endmodule

`default_nettype wire

// ==== verilog/pllcg_top.v ====
// clock generator: reference input, prescaler, loop model, path select and
// output dividers; generated clocks leave as one-cycle edge pulses on i_mclk
// assumes the reference input is synchronous to i_mclk and slower than it
`timescale 1ns/1ps
`default_nettype none
`include "pllcg_regs.vh"

// Operation
// - every generated clock comes from the one reference input, either multiplied by the loop or passed around it.
// - the basic variant offers only a times-four loop mode and a times-one bypass mode.
// - the controller has an input prescaler, an oscillator output divider and core, bus and memory dividers.
// - separate clocks go to the core, the peripheral bus, the memory interface and the oscillator output.
// - the path-select bit picks the raw reference when clear and the loop output when set, feeding all system dividers.
// - the prescaler divides the reference by any integer from one to thirty-two.
module pllcg_top #(
	parameter BASIC      = 0,                                  // 1: pin-selected x4/x1 variant
	parameter PER_W      = 16,                                 // reference period counter width
	parameter LOCK_CYC   = `PLLCG_LOCK_MAX_NS / `PLLCG_MCLK_PERIOD_NS // worst lock time in cycles
) (
	input  wire        i_mclk,                 // master clock, 200 MHz
	input  wire        i_rst,                  // async reset, active high
	input  wire        i_ce,                   // clock enable
	input  wire        i_reference_clock_input,// reference clock level
	input  wire        i_multiply_mode_select, // basic variant: 1 x4, 0 x1
	input  wire [3:0]  i_addr,                 // register index
	input  wire [31:0] i_wdata,                // write data
	input  wire        i_wr,                   // write strobe
	input  wire        i_rd,                   // read strobe
	output wire [31:0] o_rdata,                // read data, cycle after i_rd
	output wire        o_core_sys_clock,       // core clock edge pulse
	output wire        o_periph_sys_clock,     // peripheral bus clock edge pulse
	output wire        o_mem_clock,            // memory interface clock edge pulse
	output wire        o_osc_out_clock,        // oscillator output clock edge pulse
	output wire        o_loop_stable           // loop locked after reset
);

	localparam LOCK_W = 24;
	localparam [LOCK_W-1:0] LOCK_N = LOCK_CYC[LOCK_W-1:0]; // lock count cut to the timer width

	// software-visible control
	reg        path_q;
	reg        loop_rst_q;
	reg [4:0]  mult_q;
	reg [4:0]  pre_ratio_q;
	reg [4:0]  osc_ratio_q;
	reg [4:0]  core_ratio_q;
	reg [4:0]  per_ratio_q;
	reg [4:0]  mem_ratio_q;
	reg        osc_en_q;
	reg        core_en_q;
	reg        per_en_q;
	reg        mem_en_q;
	reg [31:0] rdata_q;

	// loop model state
	reg              ref_q;
	reg [PER_W-1:0]  per_cnt_q;
	reg [PER_W-1:0]  period_q;
	reg              period_ok_q;
	reg [PER_W-1:0]  acc_q;
	reg              loop_tick_q;
	reg [LOCK_W-1:0] lock_cnt_q;
	reg              stable_q;

	wire ref_tick;
	wire pre_tick;
	wire sel_tick;
	wire eff_path;
	wire [4:0] eff_mult;
	wire [PER_W:0] acc_sum;

	// ratio register readback layout
	function [31:0] div_word;
		input       en;
		input [4:0] ratio;
		begin
			div_word = 32'h00000000;
			div_word[`PLLCG_DIV_EN_BIT] = en;
			div_word[`PLLCG_RATIO_MSB:0] = ratio;
		end
	endfunction

	// register writes
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			path_q       <= `PLLCG_RST_PATH;
			loop_rst_q   <= `PLLCG_RST_LOOPRST;
			mult_q       <= `PLLCG_RST_MULT;
			pre_ratio_q  <= `PLLCG_RST_PRESCALE;
			osc_ratio_q  <= `PLLCG_RST_OSCDIV;
			core_ratio_q <= `PLLCG_RST_CORE_DIV;
			per_ratio_q  <= `PLLCG_RST_PERIPH_DIV;
			mem_ratio_q  <= `PLLCG_RST_MEM_DIV;
			osc_en_q     <= `PLLCG_RST_EN;
			core_en_q    <= `PLLCG_RST_EN;
			per_en_q     <= `PLLCG_RST_EN;
			mem_en_q     <= `PLLCG_RST_EN;
		end else if (i_ce && i_wr) begin
			case (i_addr)
				`PLLCG_IDX_CSR: begin
					path_q     <= i_wdata[`PLLCG_CSR_PATH_BIT];
					loop_rst_q <= i_wdata[`PLLCG_CSR_RESET_BIT];
				end
				`PLLCG_IDX_MULT: begin
					mult_q <= i_wdata[`PLLCG_RATIO_MSB:0];
				end
				`PLLCG_IDX_PRESCALE: begin
					pre_ratio_q <= i_wdata[`PLLCG_RATIO_MSB:0];
				end
				`PLLCG_IDX_OSCDIV: begin
					osc_ratio_q <= i_wdata[`PLLCG_RATIO_MSB:0];
					osc_en_q    <= i_wdata[`PLLCG_DIV_EN_BIT];
				end
				`PLLCG_IDX_CORE_DIV: begin
					core_ratio_q <= i_wdata[`PLLCG_RATIO_MSB:0];
					core_en_q    <= i_wdata[`PLLCG_DIV_EN_BIT];
				end
				`PLLCG_IDX_PERIPH_DIV: begin
					per_ratio_q <= i_wdata[`PLLCG_RATIO_MSB:0];
					per_en_q    <= i_wdata[`PLLCG_DIV_EN_BIT];
				end
				`PLLCG_IDX_MEM_DIV: begin
					mem_ratio_q <= i_wdata[`PLLCG_RATIO_MSB:0];
					mem_en_q    <= i_wdata[`PLLCG_DIV_EN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// register reads, data in the cycle after the strobe, zero otherwise
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= 32'h00000000;
		end else if (i_ce) begin
			rdata_q <= 32'h00000000;
			if (i_rd) begin
				case (i_addr)
					`PLLCG_IDX_CSR: begin
						rdata_q[`PLLCG_CSR_PATH_BIT]   <= path_q;
						rdata_q[`PLLCG_CSR_RESET_BIT]  <= loop_rst_q;
						rdata_q[`PLLCG_CSR_STABLE_BIT] <= stable_q;
					end
					`PLLCG_IDX_MULT:       rdata_q <= div_word(1'b0, mult_q);
					`PLLCG_IDX_PRESCALE:   rdata_q <= div_word(1'b0, pre_ratio_q);
					`PLLCG_IDX_OSCDIV:     rdata_q <= div_word(osc_en_q, osc_ratio_q);
					`PLLCG_IDX_CORE_DIV:   rdata_q <= div_word(core_en_q, core_ratio_q);
					`PLLCG_IDX_PERIPH_DIV: rdata_q <= div_word(per_en_q, per_ratio_q);
					`PLLCG_IDX_MEM_DIV:    rdata_q <= div_word(mem_en_q, mem_ratio_q);
					default:               rdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	// reference edge detect; every clock starts here
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ref_q <= 1'b0;
		end else if (i_ce) begin
			ref_q <= i_reference_clock_input;
		end
	end

	assign ref_tick = i_reference_clock_input & ~ref_q;

	// input prescaler ahead of the loop
	pllcg_div u_prescale (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_tick  (ref_tick),
		.i_en    (1'b1),
		.i_ratio (pre_ratio_q),
		.o_tick  (pre_tick)
	);

	// basic variant: pin picks x4 loop or x1 bypass
	assign eff_path = (BASIC != 0) ? i_multiply_mode_select : path_q;
	assign eff_mult = (BASIC != 0) ? `PLLCG_MULT_BASIC_LOOP :
		(mult_q < `PLLCG_MULT_MIN) ? `PLLCG_MULT_MIN :
		(mult_q > `PLLCG_MULT_MAX) ? `PLLCG_MULT_MAX : mult_q;
	assign acc_sum  = {1'b0, acc_q} + {{(PER_W-4){1'b0}}, eff_mult};

	// loop model: measure prescaled period, emit mult edges per period
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			per_cnt_q   <= {PER_W{1'b0}};
			period_q    <= {PER_W{1'b0}};
			period_ok_q <= 1'b0;
			acc_q       <= {PER_W{1'b0}};
			loop_tick_q <= 1'b0;
		end else if (i_ce) begin
			loop_tick_q <= 1'b0;
			if (loop_rst_q) begin
				per_cnt_q   <= {PER_W{1'b0}};
				period_ok_q <= 1'b0;
				acc_q       <= {PER_W{1'b0}};
			end else begin
				if (pre_tick) begin
					per_cnt_q   <= {{(PER_W-1){1'b0}}, 1'b1};
					period_q    <= per_cnt_q;
					period_ok_q <= (per_cnt_q != {PER_W{1'b0}});
				end else if (per_cnt_q != {PER_W{1'b1}}) begin
					per_cnt_q <= per_cnt_q + {{(PER_W-1){1'b0}}, 1'b1};
				end
				if (period_ok_q) begin
					if (acc_sum >= {1'b0, period_q}) begin
						acc_q       <= acc_sum[PER_W-1:0] - period_q;
						loop_tick_q <= 1'b1;
					end else begin
						acc_q <= acc_sum[PER_W-1:0];
					end
				end
			end
		end
	end

	// lock timer restarts whenever the loop is held in reset
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			lock_cnt_q <= {LOCK_W{1'b0}};
			stable_q   <= 1'b0;
		end else if (i_ce) begin
			if (loop_rst_q) begin
				lock_cnt_q <= {LOCK_W{1'b0}};
				stable_q   <= 1'b0;
			end else if (lock_cnt_q >= LOCK_N - 1'b1) begin
				stable_q <= 1'b1;
			end else begin
				lock_cnt_q <= lock_cnt_q + {{(LOCK_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// high-frequency system reference
	assign sel_tick = eff_path ? loop_tick_q : ref_tick;

	// oscillator output divider straight off the reference
	pllcg_div u_osc (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_tick  (ref_tick),
		.i_en    (osc_en_q),
		.i_ratio (osc_ratio_q),
		.o_tick  (o_osc_out_clock)
	);

	// system dividers for core, peripheral bus and memory interface
	pllcg_div u_core (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_tick  (sel_tick),
		.i_en    (core_en_q),
		.i_ratio (core_ratio_q),
		.o_tick  (o_core_sys_clock)
	);

	pllcg_div u_periph (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_tick  (sel_tick),
		.i_en    (per_en_q),
		.i_ratio (per_ratio_q),
		.o_tick  (o_periph_sys_clock)
	);

	pllcg_div u_mem (
		.i_mclk  (i_mclk),
		.i_rst   (i_rst),
		.i_ce    (i_ce),
		.i_tick  (sel_tick),
		.i_en    (mem_en_q),
		.i_ratio (mem_ratio_q),
		.o_tick  (o_mem_clock)
	);

	assign o_rdata       = rdata_q;
	assign o_loop_stable = stable_q;

endmodule

`default_nettype wire

// ==== dv/pllcg_chk.sv ====
// checker: read-back, bypass edges and lock timing of the clock generator
// assumes binding onto pllcg_top with the same lock count
`timescale 1ns/1ps
`default_nettype none
module pllcg_chk #(
	parameter LOCK_CYC = 20
) (
	input wire logic        i_mclk,                  // clock
	input wire logic        i_rst,                   // reset
	input wire logic        i_ce,                    // enable
	input wire logic        i_reference_clock_input, // reference
	input wire logic [3:0]  i_addr,                  // index
	input wire logic [31:0] i_wdata,                 // write data
	input wire logic        i_wr,                    // write
	input wire logic        i_rd,                    // read
	input wire logic [31:0] o_rdata,                 // read data
	input wire logic        o_core_sys_clock,        // core pulse
	input wire logic        o_mem_clock,             // memory pulse
	input wire logic        o_loop_stable            // lock flag
);
	logic        ref_q, path_q, lr_q, mem_q;
	logic [5:0]  core_q, q_cnt;
	logic [15:0] lk_cnt;
	wire         rise = i_reference_clock_input & ~ref_q;
	wire         quiet = &q_cnt;
	// shadow fields, lock timer, cycles since the last write
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ref_q <= 1'b0;
			path_q <= 1'b0;
			lr_q <= 1'b1;
			mem_q <= 1'b1;
			core_q <= 6'h20;
			q_cnt <= 6'h0;
			lk_cnt <= 16'h0;
		end else if (i_ce) begin
			ref_q <= i_reference_clock_input;
			q_cnt <= i_wr ? 6'h0 : q_cnt + {5'h0, ~quiet};
			lk_cnt <= lr_q ? 16'h0 : lk_cnt + {15'h0, ~&lk_cnt};
			if (i_wr && i_addr == 4'h0) begin
				path_q <= i_wdata[0];
				lr_q <= i_wdata[3];
			end
			if (i_wr && i_addr == 4'h4) core_q <= {i_wdata[15], i_wdata[4:0]};
			if (i_wr && i_addr == 4'h6) mem_q <= i_wdata[15];
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	a_bypass_core_edge: assert property (quiet && !path_q && core_q == 6'h20 && rise && i_ce |=> o_core_sys_clock)
		else $error("core pulse missing");
	a_core_on_edge: assert property (quiet && !path_q && o_core_sys_clock |-> $past(rise))
		else $error("core pulse without reference rise");
	a_mem_off: assert property (quiet && !mem_q |-> !o_mem_clock)
		else $error("pulse from disabled divider");
	a_lock_drop: assert property (i_ce && i_wr && i_addr == 4'h0 && i_wdata[3] |=> ##1 !o_loop_stable)
		else $error("stable kept in loop reset");
	a_lock_early: assert property ($rose(o_loop_stable) |-> lk_cnt >= LOCK_CYC - 2)
		else $error("stable too early");
	a_lock_late: assert property (!lr_q && lk_cnt == LOCK_CYC + 2 |-> o_loop_stable)
		else $error("stable too late");
	a_csr_read: assert property (i_ce && i_rd && i_addr == 4'h0 |=> o_rdata == {25'h0, $past(o_loop_stable), 2'h0, lr_q, 2'h0, path_q})
		else $error("control read wrong");
	a_unmapped_zero: assert property (i_ce && i_rd && i_addr > 4'h6 |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind pllcg_top pllcg_chk #(.LOCK_CYC(LOCK_CYC)) pllcg_chk_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce),
	.i_reference_clock_input(i_reference_clock_input), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_core_sys_clock(o_core_sys_clock), .o_mem_clock(o_mem_clock),
	.o_loop_stable(o_loop_stable));
`default_nettype wire

// ==== dv/pllcg_ref_osc.sv ====
// reference oscillator model: free-running square wave on the master clock
// assumes a half period of at least two master cycles
`timescale 1ns/1ps
`default_nettype none
module pllcg_ref_osc (
	input  wire logic       i_mclk, // master clock
	input  wire logic       i_rst,  // reset
	input  wire logic [3:0] i_half, // half period, cycles
	output var  logic       o_ref   // reference level
);
	logic [3:0] cnt_q;
	// toggle after each half period, never stops
	always @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 4'h1;
			o_ref <= 1'b0;
		end else if (cnt_q >= i_half) begin
			cnt_q <= 4'h1;
			o_ref <= ~o_ref;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// ==== dv/test_pllcg_top.sv ====
// testbench: register access, bypass and loop clock rates, lock wait
// assumes a short lock count and a reference of eight master cycles
`timescale 1ns/1ps
`default_nettype none
module test_pllcg_top;
	localparam LOCK = 20;
	logic        mclk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ce = 1'b1, refc, core, per, mem, osc, stab;
	logic [3:0]  addr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	int          errors = 0, n_compared = 0, c_core, c_per, c_mem, c_osc;
	logic [31:0] rst_tab [8] = '{32'h8, 32'h4, 32'h0, 32'h8000, 32'h8000, 32'h8001, 32'h8001, 32'h0};
	// clock generation
	always #2.5 mclk = ~mclk;
	pllcg_ref_osc pllcg_ref_osc_inst (.i_mclk(mclk), .i_rst(rst), .i_half(4'h4), .o_ref(refc));
	pllcg_top #(.LOCK_CYC(LOCK)) pllcg_top_inst (.i_mclk(mclk), .i_rst(rst), .i_ce(ce),
		.i_reference_clock_input(refc), .i_multiply_mode_select(1'b0), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_core_sys_clock(core), .o_periph_sys_clock(per),
		.o_mem_clock(mem), .o_osc_out_clock(osc), .o_loop_stable(stab));
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %0h vs %0h", $time, got, exp);
		end
	endtask
	// pulse counts may be off by one from window alignment
	task automatic cmp_n(input int got, input int exp);
		cmp((got >= exp - 1 && got <= exp + 1) ? exp : got, exp);
	endtask
	task automatic put(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic get(input logic [3:0] a, input logic [31:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		cmp(rdata, exp);
	endtask
	// settle, then count pulses over 64 cycles
	task automatic count(input int e_core, input int e_per, input int e_mem);
		c_core = 0;
		c_per = 0;
		c_mem = 0;
		c_osc = 0;
		repeat (40) @(posedge mclk);
		repeat (64) begin
			@(posedge mclk);
			c_core += core;
			c_per += per;
			c_mem += mem;
			c_osc += osc;
		end
		cmp_n(c_core, e_core);
		cmp_n(c_per, e_per);
		cmp_n(c_mem, e_mem);
		cmp_n(c_osc, 8);
	endtask
	task automatic test_done;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++) get(a[3:0], rst_tab[a]);
		get(4'hF, 32'h0);
		put(4'h6, 32'hFFFFFFFF);
		get(4'h6, 32'h801F);
		put(4'h0, 32'h49);
		get(4'h0, 32'h9);
		put(4'h1, 32'h1F);
		get(4'h1, 32'h1F);
		put(4'h1, 32'h1);
		get(4'h1, 32'h1);
		put(4'h0, 32'h8);
		put(4'h6, 32'h1);
		count(8, 4, 0);
		put(4'h6, 32'h8001);
		put(4'h5, 32'h8003);
		put(4'h4, 32'h8001);
		count(4, 2, 4);
		put(4'h4, 32'h8000);
		put(4'h5, 32'h8001);
		for (int n = 0; n < 2; n++) begin
			put(4'h0, 32'h8);
			put(4'h2, 32'(n));
			repeat (26) @(posedge mclk);
			put(4'h0, 32'h0);
			get(4'h0, 32'h0);
			cmp({31'h0, stab}, 32'h0);
			repeat (LOCK + 4) @(posedge mclk);
			cmp({31'h0, stab}, 32'h1);
			get(4'h0, 32'h40);
			put(4'h0, 32'h41);
			count(32 / (n + 1), 16 / (n + 1), 16 / (n + 1));
			put(4'h0, 32'h49);
			get(4'h0, 32'h9);
		end
		// a write while the clock enable is low must be ignored
		ce <= 1'b0;
		put(4'h6, 32'h0);
		ce <= 1'b1;
		get(4'h6, 32'h8001);
		test_done;
	end
	// watchdog against a hang
	initial begin
		#50000;
		errors++;
		test_done;
	end
endmodule
`default_nettype wire
